/* dsw_pkg.sv */
// Purpose: Shared constants and types of the dual switch control port.
// Assumes: 40 MHz system clock; 16-bit serial frames, MSB first.
// Notes:   Long timeouts are also top-level parameters for simulation.
package dsw_pkg;
  // Clock rate and documented times
  localparam int unsigned MCLK_HZ     = 40_000_000;
  localparam int unsigned T_WD_MS     = 310;
  localparam int unsigned T_IN_MS     = 250;
  localparam int unsigned T_CLKMON_US = 50;
  // Longest times round down to whole cycles
  localparam int unsigned WD_CYC_DEF     = MCLK_HZ / 1000 * T_WD_MS;
  localparam int unsigned IN_CYC_DEF     = MCLK_HZ / 1000 * T_IN_MS;
  localparam int unsigned CLKMON_CYC_DEF = MCLK_HZ / 1_000_000 * T_CLKMON_US;
  localparam int unsigned CNT_W          = 24;
  // Frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned BIT_W      = 4;
  localparam int unsigned FCNT_W     = 5;
  localparam int unsigned DATA_W     = 9;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned ADDR_LSB   = 9;
  localparam int unsigned WATCHDOG_TOGGLE_BIT_POS   = 15;
  localparam logic [FCNT_W-1:0] FCNT_ONE  = 5'h01;
  localparam logic [FCNT_W-1:0] FRAME_CNT = 5'h10;
  // Channels, fault groups and the synchroniser vector
  localparam int unsigned NCH    = 2;
  localparam int unsigned FLT_W  = 4;
  localparam int unsigned DIAG_W = 2;
  localparam int unsigned STAT_W = 3;
  localparam int unsigned STAT_CLK = 2;
  localparam int unsigned SYNC_W = 23;
  localparam logic [SYNC_W-1:0] SYNC_RST = {1'b1, {(SYNC_W-1){1'b0}}};
  // Write addresses and configuration layout
  localparam int unsigned NUM_CFG    = 8;
  localparam int unsigned CFGI_W     = 3;
  localparam int unsigned CFG_GCR    = 0;
  localparam int unsigned GCR_WDOFF  = 0;
  localparam int unsigned GCR_CLKMON = 1;
  localparam logic [ADDR_W-1:0] ADR_RDSEL = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_CFG0  = 4'h1;
  localparam logic [DATA_W-1:0] CFG_RST   = 9'h000;
  // Read sources: 13 registers, anything else echoes the last word
  localparam logic [ADDR_W-1:0] RS_STAT   = 4'h0;
  localparam logic [ADDR_W-1:0] RS_FLT0   = 4'h1;
  localparam logic [ADDR_W-1:0] RS_DIAG0  = 4'h3;
  localparam logic [ADDR_W-1:0] RS_CFG0   = 4'h5;
  localparam logic [ADDR_W-1:0] RS_LAST   = 4'hc;
  localparam logic [ADDR_W-1:0] RDSEL_RST = 4'hf;
  // Device operating modes
  typedef enum logic [1:0] {M_SLEEP, M_NORMAL, M_FAILSAFE} dsw_mode_t;
endpackage

/* dsw_spi_ctrl.sv */
// Purpose: Serial control port, wake/watchdog, direct inputs and flags.
// Assumes: sclk_i idles low around chip select edges; pins are async.
// Notes:   Open-drain flags are given as enables only; pin low when set.
`timescale 1ns/1ps
module dsw_spi_ctrl
  import dsw_pkg::*;
#(
  parameter int unsigned WD_CYC     = WD_CYC_DEF,
  parameter int unsigned IN_CYC     = IN_CYC_DEF,
  parameter int unsigned CLKMON_CYC = CLKMON_CYC_DEF
) (
  // Clock and reset
  input  wire logic           mclk_i,
  input  wire logic           arst_n_i,
  // Serial port pins
  input  wire logic           sclk_i,
  input  wire logic           chip_select_n_i,
  input  wire logic           si_i,
  output logic                so_o,
  output logic                so_oe_o,
  // Wake, direct control and configuration pins
  input  wire logic           wake_reset_n_i,
  input  wire logic [NCH-1:0] direct_in_i,
  input  wire logic [NCH-1:0] load_profile_select_i,
  input  wire logic           pwm_clk_i,
  input  wire logic           vdd_ok_i,
  // Analog indications
  input  wire logic           sense_ready_i,
  input  wire logic [NCH-1:0] overcurrent_fault_i,
  input  wire logic [NCH-1:0] overtemperature_fault_i,
  input  wire logic [NCH-1:0] severe_short_fault_i,
  input  wire logic [NCH-1:0] vpwr_short_fault_i,
  input  wire logic [NCH-1:0] open_load_on_fault_i,
  input  wire logic [NCH-1:0] open_load_off_fault_i,
  input  wire logic           overvoltage_fault_i,
  input  wire logic           undervoltage_fault_i,
  // Channel control and flags
  output logic [NCH-1:0]      channel_on_o,
  output logic [NCH-1:0]      motor_profile_o,
  output logic                fault_flag_n_oe_o,
  output logic                failsafe_flag_n_oe_o,
  output logic                sense_strobe_n_oe_o,
  output logic                normal_mode_o
);

  localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_CYC - 1);
  localparam logic [CNT_W-1:0] IN_LAST = CNT_W'(IN_CYC - 1);
  localparam logic [CNT_W-1:0] CM_LAST = CNT_W'(CLKMON_CYC - 1);

  // Reset release through two flops
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  logic [SYNC_W-1:0] sy1_q;
  logic [SYNC_W-1:0] sy2_q;
  logic [3+NCH-1:0]  edge_q;
  logic              cs_n_s, wake_s, pwm_s, sense_s, vdd_s, ov_s, uv_s;
  logic [NCH-1:0]    in_s, prof_s, oc_s, ot_s, sc_s, sh_s, oln_s, olf_s;
  logic              cs_n_p, wake_p, pwm_p;
  logic [NCH-1:0]    in_p;
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sy1_q  <= SYNC_RST;
      sy2_q  <= SYNC_RST;
      edge_q <= {SYNC_RST[SYNC_W-1], {(NCH+2){1'b0}}}; // Idle levels: no false edge
    end else begin
      sy1_q  <= {chip_select_n_i, open_load_off_fault_i, open_load_on_fault_i,
                 vpwr_short_fault_i, severe_short_fault_i, overtemperature_fault_i,
                 overcurrent_fault_i, undervoltage_fault_i, overvoltage_fault_i,
                 vdd_ok_i, sense_ready_i, pwm_clk_i, wake_reset_n_i,
                 load_profile_select_i, direct_in_i};
      sy2_q  <= sy1_q;
      edge_q <= {cs_n_s, wake_s, pwm_s, in_s};
    end
  end
  assign {cs_n_s, olf_s, oln_s, sh_s, sc_s, ot_s, oc_s, uv_s, ov_s,
          vdd_s, sense_s, pwm_s, wake_s, prof_s, in_s} = sy2_q;
  assign {cs_n_p, wake_p, pwm_p, in_p} = edge_q;

  // Edge decode in the system domain
  wire logic           cs_rise   = cs_n_s & ~cs_n_p;
  wire logic           cs_fall   = ~cs_n_s & cs_n_p;
  wire logic           wake_rise = wake_s & ~wake_p;
  wire logic           pwm_edge  = pwm_s ^ pwm_p;
  wire logic [NCH-1:0] in_rise   = in_s & ~in_p;
  wire logic [NCH-1:0] in_edge   = in_s ^ in_p;

  // Link side: selection gates everything, the pin itself is the clear
  wire logic link_clr_n = rst_n_q & ~chip_select_n_i;
  logic                  rx_arm_q;
  logic [FRAME_BITS-1:0] rx_sh_q;
  logic [FCNT_W-1:0]     rx_cnt_q;
  logic [BIT_W-1:0]      tx_idx_q;
  logic [FRAME_BITS-1:0] so_word_q;
  wire logic [FCNT_W-1:0] rx_cnt_d = !rx_arm_q ? FCNT_ONE :
                                     (rx_cnt_q == FRAME_CNT) ? rx_cnt_q :
                                     rx_cnt_q + 1'b1;

  // First falling edge of a frame arms the bit counter
  always_ff @(negedge sclk_i or negedge link_clr_n) begin
    if (!link_clr_n) begin
      rx_arm_q <= 1'b0;
    end else begin
      rx_arm_q <= 1'b1;
    end
  end

  // Input shifter samples on falling edges, MSB first
  always_ff @(negedge sclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rx_sh_q  <= '0;
      rx_cnt_q <= '0;
    end else if (!chip_select_n_i) begin
      rx_sh_q  <= {rx_sh_q[FRAME_BITS-2:0], si_i};
      rx_cnt_q <= rx_cnt_d;
    end
  end

  // Output bit index advances on rising edges while selected
  always_ff @(posedge sclk_i or negedge link_clr_n) begin
    if (!link_clr_n) begin
      tx_idx_q <= '0;
    end else begin
      tx_idx_q <= tx_idx_q + 1'b1;
    end
  end
  // D15 shows before the first rising edge, so this is a mux on a flop word
  assign so_o = so_word_q[~tx_idx_q];

  // Frame decode; shifter is quiet once select has risen
  wire logic              frame_ok = cs_rise & (rx_cnt_q == FRAME_CNT);
  wire logic [ADDR_W-1:0] rx_addr  = rx_sh_q[ADDR_LSB +: ADDR_W];
  wire logic [DATA_W-1:0] rx_data  = rx_sh_q[DATA_W-1:0];
  wire logic              rx_watchdog_toggle_bit  = rx_sh_q[WATCHDOG_TOGGLE_BIT_POS];
  wire logic              wr_en    = frame_ok & wake_s;

  // Writable registers, forced to reset while wake is low
  logic [DATA_W-1:0]     cfg_q [NUM_CFG];
  logic [ADDR_W-1:0]     rd_sel_q;
  logic [ADDR_W-1:0]     src_q;
  logic [FRAME_BITS-1:0] rx_word_q;
  logic [FRAME_BITS-1:0] rd_word;
  for (genvar g = 0; g < NUM_CFG; g++) begin : g_cfg
    wire logic hit = wr_en & (rx_addr == ADR_CFG0 + ADDR_W'(g));
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
        cfg_q[g] <= CFG_RST;
      end else if (!wake_s) begin
        cfg_q[g] <= CFG_RST;
      end else if (hit) begin
        cfg_q[g] <= rx_data;
      end
    end
  end
  wire logic wd_off    = cfg_q[CFG_GCR][GCR_WDOFF];
  wire logic clkmon_en = cfg_q[CFG_GCR][GCR_CLKMON];

  // Read select, echo word and output word capture
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_sel_q  <= RDSEL_RST;
      src_q     <= RDSEL_RST;
      rx_word_q <= '0;
      so_word_q <= '0;
    end else begin
      if (!wake_s) begin
        rd_sel_q <= RDSEL_RST;
      end else if (wr_en && rx_addr == ADR_RDSEL) begin
        rd_sel_q <= rx_data[ADDR_W-1:0];
      end
      if (frame_ok) begin
        rx_word_q <= rx_sh_q;
      end
      if (cs_fall) begin
        so_word_q <= rd_word;
        src_q     <= rd_sel_q;
      end
    end
  end

  // Sticky fault bits; a read clears, a fault still present wins
  logic [NCH-1:0][FLT_W-1:0]  flt_q;
  logic [NCH-1:0][DIAG_W-1:0] diag_q;
  logic [STAT_W-1:0]          stat_q;
  logic                       clk_fail_ev;
  for (genvar c = 0; c < NCH; c++) begin : g_flt
    wire logic [FLT_W-1:0]  f_ev  = {sh_s[c], sc_s[c], ot_s[c], oc_s[c]};
    wire logic [DIAG_W-1:0] d_ev  = {olf_s[c], oln_s[c]};
    wire logic              f_clr = frame_ok & (src_q == RS_FLT0 + ADDR_W'(c));
    wire logic              d_clr = frame_ok & (src_q == RS_DIAG0 + ADDR_W'(c));
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
        flt_q[c]  <= '0;
        diag_q[c] <= '0;
      end else begin
        flt_q[c]  <= (flt_q[c] & ~{FLT_W{f_clr}}) | f_ev;
        diag_q[c] <= (diag_q[c] & ~{DIAG_W{d_clr}}) | d_ev;
      end
    end
  end
  wire logic              s_clr = frame_ok & (src_q == RS_STAT);
  wire logic [STAT_W-1:0] s_ev  = {clk_fail_ev, uv_s, ov_s};
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~{STAT_W{s_clr}}) | s_ev;
    end
  end

  // Read word: 13 registers by select, anything else echoes
  logic [ADDR_W-1:0] cfg_off;
  logic [DATA_W-1:0] rd_data;
  dsw_mode_t         mode_q;
  assign cfg_off = rd_sel_q - RS_CFG0;
  assign rd_data =
    (rd_sel_q == RS_STAT) ? {mode_q == M_FAILSAFE, mode_q == M_NORMAL,
                             {(DATA_W-2-STAT_W){1'b0}}, stat_q} :
    (rd_sel_q < RS_DIAG0) ? {{(DATA_W-FLT_W){1'b0}}, flt_q[rd_sel_q[0] ^ 1'b1]} :
    (rd_sel_q < RS_CFG0)  ? {{(DATA_W-DIAG_W){1'b0}}, diag_q[rd_sel_q[0] ^ 1'b1]} :
                            cfg_q[cfg_off[CFGI_W-1:0]];
  assign rd_word = (rd_sel_q > RS_LAST) ? rx_word_q :
                   {{(FRAME_BITS-ADDR_W-DATA_W){1'b0}}, rd_sel_q, rd_data};

  // External PWM clock monitor: no edge for the timeout is a failure
  logic [CNT_W-1:0] cm_cnt_q;
  wire logic cm_to = cm_cnt_q == CM_LAST;
  assign clk_fail_ev = clkmon_en & cm_to;
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cm_cnt_q <= '0;
    end else if (!clkmon_en || pwm_edge) begin
      cm_cnt_q <= '0;
    end else if (!cm_to) begin
      cm_cnt_q <= cm_cnt_q + 1'b1;
    end
  end

  // Direct input activity timers
  logic [NCH-1:0]   in_on_q;
  logic [CNT_W-1:0] in_tmr_q [NCH];
  for (genvar c = 0; c < NCH; c++) begin : g_in
    wire logic in_to = in_tmr_q[c] == IN_LAST;
    always_ff @(posedge mclk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
        in_tmr_q[c] <= '0;
        in_on_q[c]  <= 1'b0;
      end else if (in_s[c] || in_edge[c]) begin
        in_tmr_q[c] <= '0;
        in_on_q[c]  <= 1'b1;
      end else if (in_to) begin
        in_on_q[c]  <= 1'b0;
      end else begin
        in_tmr_q[c] <= in_tmr_q[c] + 1'b1;
      end
    end
  end
  wire logic in_idle = ~|in_on_q & ~|in_s;

  // Serial watchdog on the first bit of each word
  logic             wd_run_q;
  logic             wd_last_q;
  logic [CNT_W-1:0] wd_cnt_q;
  wire logic wd_tog    = frame_ok & (rx_watchdog_toggle_bit != wd_last_q);
  wire logic wd_to     = wd_cnt_q == WD_LAST;
  wire logic wd_expire = wd_run_q & wd_to & ~wd_off;
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wd_run_q  <= 1'b0;
      wd_last_q <= 1'b0;
      wd_cnt_q  <= '0;
    end else if (!wake_s) begin
      wd_run_q  <= 1'b0;
      wd_cnt_q  <= '0;
    end else if (wake_rise) begin
      wd_run_q  <= 1'b1;
      wd_last_q <= 1'b0;
      wd_cnt_q  <= '0;
    end else if (wd_tog) begin
      wd_last_q <= rx_watchdog_toggle_bit;
      wd_cnt_q  <= '0;
    end else if (wd_run_q && !wd_to) begin
      wd_cnt_q  <= wd_cnt_q + 1'b1;
    end
  end

  // Operating mode
  dsw_mode_t mode_d;
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      M_SLEEP: begin
        if (wake_rise || |in_rise) begin
          mode_d = M_NORMAL;
        end
      end
      M_NORMAL: begin
        if (wd_expire) begin
          mode_d = M_FAILSAFE;
        end else if (!wake_s && in_idle) begin
          mode_d = M_SLEEP;
        end
      end
      M_FAILSAFE: begin
        if (!wake_s && in_idle) begin
          mode_d = M_SLEEP;
        end
      end
      default: begin
        mode_d = M_SLEEP;
      end
    endcase
  end

  // Channel drive, profiles and flags
  wire logic [NCH-1:0] ch_d   = (mode_q != M_SLEEP) ? in_s : '0;
  wire logic [NCH-1:0] ch_off = channel_on_o & ~ch_d;
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_q               <= M_SLEEP;
      channel_on_o         <= '0;
      motor_profile_o      <= '1;
      fault_flag_n_oe_o    <= 1'b0;
      failsafe_flag_n_oe_o <= 1'b0;
      sense_strobe_n_oe_o  <= 1'b0;
      normal_mode_o        <= 1'b0;
      so_oe_o              <= 1'b0;
    end else begin
      mode_q               <= mode_d;
      channel_on_o         <= ch_d;
      motor_profile_o      <= prof_s;
      fault_flag_n_oe_o    <= |flt_q | |diag_q | |stat_q;
      failsafe_flag_n_oe_o <= (mode_q == M_FAILSAFE) | ~vdd_s;
      normal_mode_o        <= mode_q == M_NORMAL;
      so_oe_o              <= ~cs_n_s;
      if (|ch_off) begin
        sense_strobe_n_oe_o <= 1'b0;
      end else if (sense_s && |channel_on_o) begin
        sense_strobe_n_oe_o <= 1'b1;
      end
    end
  end

  // Checks
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_q);
  sequence s_frame_end;
    cs_rise ##0 (rx_cnt_q == FRAME_CNT);
  endsequence
  sequence s_wd_timeout;
    wd_run_q && !wd_off && wd_to && (mode_q == M_NORMAL);
  endsequence
  sequence s_sleep_hit;
    (mode_q == M_SLEEP) ##0 (|in_rise);
  endsequence
  chk_echo_latch: assert property (s_frame_end |=> rx_word_q == $past(rx_sh_q))
    else $error("echo word not latched at frame end");
  chk_so_load: assert property (cs_fall |=> so_word_q == $past(rd_word))
    else $error("output word not loaded at select fall");
  chk_so_hiz: assert property (cs_n_s |=> !so_oe_o)
    else $error("serial output driven while deselected");
  chk_ch_follow: assert property ((mode_q != M_SLEEP) |=> channel_on_o == $past(in_s))
    else $error("channel does not follow direct input");
  chk_input_wake: assert property (s_sleep_hit |=> mode_q == M_NORMAL)
    else $error("input edge did not wake");
  chk_wd_failsafe: assert property (s_wd_timeout |=> mode_q == M_FAILSAFE)
    else $error("watchdog timeout missed");
  chk_wd_restart: assert property (wd_tog && wake_s && !wake_rise |=> wd_cnt_q == '0)
    else $error("watchdog not restarted by toggle");
  chk_cfg_held: assert property (!wake_s |=> cfg_q[CFG_GCR] == CFG_RST)
    else $error("register not held in reset");
  chk_fault_flag: assert property ((|flt_q || |diag_q || |stat_q) |=> fault_flag_n_oe_o)
    else $error("fault flag not asserted");
  chk_stat_clear: assert property (s_clr && !(|s_ev) |=> stat_q == '0)
    else $error("status not cleared by read");
  chk_clk_fail: assert property (clk_fail_ev |=> stat_q[STAT_CLK])
    else $error("clock failure not recorded");
  chk_strobe_off: assert property (|($past(channel_on_o) & ~channel_on_o)
                                   |-> !sense_strobe_n_oe_o)
    else $error("strobe not released at turn-off");
  chk_fs_flag: assert property ((mode_q == M_FAILSAFE) |=> failsafe_flag_n_oe_o)
    else $error("fail-safe flag missing");
  chk_sleep_entry: assert property (!wake_s && in_idle && mode_q == M_NORMAL
                                    && !wd_expire |=> mode_q == M_SLEEP)
    else $error("sleep not entered");

endmodule

/* dsw_mcu_model.sv */
// Purpose: Serial bus master standing for the controller.
// Assumes: 125 ns serial clock, running only inside frames.
// Notes:   Output is read just before each rising clock edge.
`timescale 1ns/1ps
module dsw_mcu_model (
  // Serial pins
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      si_o,
  input  wire logic so_i
);
  // Idle: clock low, deselected, data at its pull-down level
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  // One whole frame; data moves 31.5 ns after each fall to keep hold time
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_o = 1'b0;
    #500;
    for (int i = 15; i >= 0; i--) begin
      si_o = tx[i];
      #31;
      rx[i] = so_i;
      sclk_o = 1'b1;
      #62.5;
      sclk_o = 1'b0;
      #31.5;
    end
    #100;
    si_o   = 1'b0;
    cs_n_o = 1'b1;
    #1000;
  endtask
endmodule

/* dual_switch_spi_control_port_bench.sv */
// Purpose: Self-checking bench of the dual switch control port.
// Assumes: Short timeouts set by parameters; pins change at falling mclk.
// Notes:   Each frame flips the watched bit so the watchdog stays fed.
`timescale 1ns/1ps
module dual_switch_spi_control_port_bench;
  import dsw_pkg::*;
  localparam int unsigned WD_T = 600;
  localparam int unsigned IN_T = 100;
  logic        mclk_i   = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        wake_n   = 1'b0;
  logic        vdd      = 1'b1;
  logic        sready   = 1'b0;
  logic [1:0]  din      = 2'b00;
  logic [1:0]  lps      = 2'b11;
  logic [13:0] flt      = '0;
  logic        pwm      = 1'b0;
  logic        pwm_run  = 1'b0;
  logic        sclk, cs_n, si, so, so_oe, wdb;
  logic [1:0]  chon, motor;
  logic        fflag, fsflag, strobe, nm;
  logic [15:0] rx;
  int          failures = 0;
  int          checked  = 0;
  int          cycles   = 0;
  // Clock and hang guard
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      give_verdict();
    end
  end
  // External PWM clock, toggled at falling edges while running
  always @(negedge mclk_i) begin
    if (pwm_run) begin
      pwm <= ~pwm;
    end
  end
  dsw_mcu_model i_mcu (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so));
  dsw_spi_ctrl #(.WD_CYC(WD_T), .IN_CYC(IN_T), .CLKMON_CYC(50)) i_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .chip_select_n_i(cs_n),
    .si_i(si), .so_o(so), .so_oe_o(so_oe), .wake_reset_n_i(wake_n),
    .direct_in_i(din), .load_profile_select_i(lps), .pwm_clk_i(pwm),
    .vdd_ok_i(vdd), .sense_ready_i(sready), .overcurrent_fault_i(flt[1:0]),
    .overtemperature_fault_i(flt[3:2]), .severe_short_fault_i(flt[5:4]),
    .vpwr_short_fault_i(flt[7:6]), .open_load_on_fault_i(flt[9:8]),
    .open_load_off_fault_i(flt[11:10]), .overvoltage_fault_i(flt[12]),
    .undervoltage_fault_i(flt[13]), .channel_on_o(chon), .motor_profile_o(motor),
    .fault_flag_n_oe_o(fflag), .failsafe_flag_n_oe_o(fsflag),
    .sense_strobe_n_oe_o(strobe), .normal_mode_o(nm));
  // Compare and count
  task automatic chk(input string nm_s, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm_s, e, g);
    end
  endtask
  // One frame with the watched bit flipped
  task automatic frame(input logic [3:0] a, input logic [8:0] d);
    wdb = ~wdb;
    i_mcu.xfer({wdb, 2'b00, a, d}, rx);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic give_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    wdb = 1'b0;
    wait_n(5);
    arst_n_i = 1'b1;
    wait_n(8);
    chk("sleep", 16'h0, {15'h0, nm});
    chk("motor", 16'h3, {14'h0, motor});
    chk("so_oe idle", 16'h0, {15'h0, so_oe});
    // Direct control, wake by input, strobe, input timeout
    din = 2'b01;
    lps = 2'b01;
    wait_n(6);
    chk("nm in", 16'h1, {15'h0, nm});
    chk("chon", 16'h1, {14'h0, chon});
    chk("motor", 16'h1, {14'h0, motor});
    sready = 1'b1;
    wait_n(4);
    chk("strobe", 16'h1, {15'h0, strobe});
    din = 2'b00;
    wait_n(4);
    chk("chon", 16'h0, {14'h0, chon});
    chk("strobe", 16'h0, {15'h0, strobe});
    sready = 1'b0;
    wait_n(IN_T + 10);
    chk("sleep", 16'h0, {15'h0, nm});
    // Wake by the wake pin, then frames
    wake_n = 1'b1;
    wait_n(6);
    chk("nm wake", 16'h1, {15'h0, nm});
    wait_n(200);
    frame(4'hd, 9'h15a);
    frame(4'he, 9'h0a5);
    chk("echo", {1'b1, 2'b00, 4'hd, 9'h15a}, rx);
    frame(ADR_CFG0, 9'h1a4);
    frame(ADR_RDSEL, {5'h0, RS_CFG0});
    // Output enable looked at after select falls, before the first clock of a frame
    fork
      frame(4'hd, 9'h000);
      begin
        wait_n(20);
        chk("so_oe sel", 16'h1, {15'h0, so_oe});
      end
    join
    chk("cfg0", {3'b000, RS_CFG0, 9'h1a4}, rx);
    // Fault bits set, read, then cleared by the read
    flt[0] = 1'b1;
    flt[8] = 1'b1;
    wait_n(6);
    chk("fflag", 16'h1, {15'h0, fflag});
    flt = '0;
    frame(ADR_RDSEL, {5'h0, RS_FLT0});
    frame(4'hd, 9'h000);
    chk("flt0", {3'b000, RS_FLT0, 9'h001}, rx);
    frame(ADR_RDSEL, {5'h0, RS_DIAG0});
    chk("flt0 clr", {3'b000, RS_FLT0, 9'h000}, rx);
    frame(4'hd, 9'h000);
    chk("diag0", {3'b000, RS_DIAG0, 9'h001}, rx);
    // Clock monitor on: a running clock passes, a still one fails
    pwm_run = 1'b1;
    frame(ADR_CFG0, 9'h002);
    frame(ADR_RDSEL, {5'h0, RS_STAT});
    frame(4'hd, 9'h000);
    chk("stat run", {3'b000, RS_STAT, 9'h080}, rx);
    pwm_run = 1'b0;
    wait_n(60);
    frame(4'hd, 9'h000);
    chk("stat", {3'b000, RS_STAT, 9'h084}, rx);
    chk("fsflag fed", 16'h0, {15'h0, fsflag});
    // Every fault input pin pulls the fault flag; a mid-run reset clears it first
    for (int k = 0; k < 14; k++) begin
      arst_n_i = 1'b0;
      wait_n(2);
      arst_n_i = 1'b1;
      wait_n(6);
      chk("fflag none", 16'h0, {15'h0, fflag});
      flt = 14'h0001 << k;
      wait_n(6);
      chk("fflag kind", 16'h1, {15'h0, fflag});
      flt = '0;
    end
    vdd = 1'b0;
    wait_n(6);
    chk("fs vdd", 16'h1, {15'h0, fsflag});
    vdd = 1'b1;
    // Wake pin low clears writable registers, so load one first
    frame(ADR_CFG0, 9'h1a4);
    wake_n = 1'b0;
    wait_n(4);
    wake_n = 1'b1;
    wdb = 1'b0;
    wait_n(200);
    frame(ADR_RDSEL, {5'h0, RS_CFG0});
    frame(4'hd, 9'h000);
    chk("cfg0 rst", {3'b000, RS_CFG0, CFG_RST}, rx);
    // Frames stop, watchdog runs out
    wait_n(WD_T + 10);
    chk("fsflag", 16'h1, {15'h0, fsflag});
    chk("nm fs", 16'h0, {15'h0, nm});
    give_verdict();
  end
endmodule
